/* File: dmac_pkg.sv */
package dmac_pkg;
    localparam int  NUM_CH      = 2;
    localparam int  AW          = 16;
    localparam int  CW          = 11;
    localparam int  DW          = 16;
    localparam int  SRC_W       = 4;
    localparam int  FIFO_DEPTH  = 16;
    localparam int  HOLD_DLY    = 2;
    localparam int  CLK_HZ      = 20000000;
    localparam logic [CW-1:0] MAX_COUNT = 11'h400;
    // trigger source codes
    localparam logic [SRC_W-1:0] SRC_ADC   = 4'h0;
    localparam logic [SRC_W-1:0] SRC_CSI00 = 4'h1;
    localparam logic [SRC_W-1:0] SRC_CSI01 = 4'h2;
    localparam logic [SRC_W-1:0] SRC_CSI10 = 4'h3;
    localparam logic [SRC_W-1:0] SRC_UART0 = 4'h4;
    localparam logic [SRC_W-1:0] SRC_UART1 = 4'h5;
    localparam logic [SRC_W-1:0] SRC_UART3 = 4'h6;
    localparam logic [SRC_W-1:0] SRC_IIC10 = 4'h7;
    localparam logic [SRC_W-1:0] SRC_TMR0  = 4'h8;
    localparam logic [SRC_W-1:0] SRC_TMR1  = 4'h9;
    localparam logic [SRC_W-1:0] SRC_TMR4  = 4'hA;
    localparam logic [SRC_W-1:0] SRC_TMR5  = 4'hB;
    localparam int  NUM_SRC     = 12;
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } dmac_state_e;
endpackage

/* File: dmac_fifo.sv */
`timescale 1ns/1ps
module dmac_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)
(
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r;
    logic [PW-1:0]    rp_r;
    logic [PW:0]      cnt_r;
    logic             do_wr;
    logic             do_rd;

    assign wr_ready_out = (cnt_r != (PW+1)'(DEPTH));
    assign rd_valid_out = (cnt_r != '0);
    assign do_wr        = wr_valid_in && wr_ready_out;
    assign do_rd        = rd_valid_out && rd_ready_in;
    assign rd_data_out  = mem_r[rp_r];

    always_ff @(posedge core_clk_in)
    begin
        if (do_wr)
        begin
            mem_r[wp_r] <= wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wp_r <= wp_r + 1'b1;
            end
            if (do_rd)
            begin
                rp_r <= rp_r + 1'b1;
            end
            if (do_wr && !do_rd)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

/* File: dmac_top.sv */
`timescale 1ns/1ps
module dmac_top
(
    input  wire logic                               core_clk_in,
    input  wire logic                               rst_in,
    // peripheral interrupt requests, one pulse per event
    input  wire logic [dmac_pkg::NUM_SRC-1:0]       irq_src_in,
    // per-channel configuration
    input  wire logic [1:0]                         ch_enable_in,
    input  wire logic [1:0]                         ch_wide_in,
    input  wire logic [1:0]                         ch_to_ram_in,
    input  wire logic [1:0]                         channel_hold_bit_in,
    input  wire logic [1:0]                         ch_load_in,
    input  wire logic [2*dmac_pkg::SRC_W-1:0]       ch_src_sel_in,
    input  wire logic [2*dmac_pkg::AW-1:0]          ch_sfr_addr_in,
    input  wire logic [2*dmac_pkg::AW-1:0]          ch_ram_addr_in,
    input  wire logic [2*dmac_pkg::CW-1:0]          ch_count_in,
    // memory bus
    output logic                                    cpu_stall_out,
    output logic                                    mem_req_out,
    output logic                                    mem_we_out,
    output logic                                    mem_sfr_out,
    output logic                                    mem_wide_out,
    output logic [dmac_pkg::AW-1:0]                 mem_addr_out,
    output logic [dmac_pkg::DW-1:0]                 mem_wdata_out,
    input  wire logic [dmac_pkg::DW-1:0]            mem_rdata_in,
    // status
    output logic [1:0]                              ch_busy_out,
    output logic [1:0]                              ch_done_irq_out,
    output logic [2*dmac_pkg::CW-1:0]               ch_remain_out
);
    localparam int N  = dmac_pkg::NUM_CH;
    localparam int AW = dmac_pkg::AW;
    localparam int CW = dmac_pkg::CW;
    localparam int SW = dmac_pkg::SRC_W;
    localparam int HD = dmac_pkg::HOLD_DLY;

    dmac_pkg::dmac_state_e state_r;
    logic                  cur_ch_r;
    logic [N-1:0]          pend_r;
    logic [N-1:0]          active_r;
    logic [N-1:0]          hold_eff;
    logic [N-1:0]          trig;
    logic [N-1:0]          grant;
    logic [HD-1:0]         hold_dly_r [N];
    logic [AW-1:0]         ram_addr_r [N];
    logic [AW-1:0]         sfr_addr_r [N];
    logic [CW-1:0]         count_r    [N];
    logic [N-1:0]          done_r;
    logic                  fifo_wr_ready;
    logic [dmac_pkg::DW-1:0] fifo_rdata;
    logic                  fifo_rd_valid;
    logic                  fifo_rd_ready;
    logic [AW-1:0]         rd_addr;
    logic [AW-1:0]         wr_addr;
    logic                  cur_wide;
    logic                  cur_to_ram;
    logic                  start;
    logic                  start_ch;

    function automatic logic src_hit(input logic [SW-1:0] sel,
                                     input logic [dmac_pkg::NUM_SRC-1:0] s);
        logic hit;
        hit = 1'b0;
        if (sel < SW'(dmac_pkg::NUM_SRC))
        begin
            hit = s[sel];
        end
        return hit;
    endfunction

    generate
        for (genvar c = 0; c < N; c++)
        begin : g_ch
            // hold bit travels two clocks before it blocks a start
            always_ff @(posedge core_clk_in)
            begin
                if (rst_in)
                begin
                    hold_dly_r[c] <= '0;
                end
                else
                begin
                    hold_dly_r[c] <= {hold_dly_r[c][HD-2:0],
                                      channel_hold_bit_in[c]};
                end
            end
            // release acts at once; set acts after the delay
            assign hold_eff[c] = channel_hold_bit_in[c] &&
                                 hold_dly_r[c][HD-1];
            assign trig[c] = active_r[c] &&
                             src_hit(ch_src_sel_in[c*SW +: SW],
                                     irq_src_in);

            always_ff @(posedge core_clk_in)
            begin
                if (rst_in)
                begin
                    pend_r[c] <= 1'b0;
                end
                else if (ch_load_in[c])
                begin
                    pend_r[c] <= 1'b0;
                end
                else if (trig[c])
                begin
                    pend_r[c] <= 1'b1;
                end
                else if (grant[c])
                begin
                    pend_r[c] <= 1'b0;
                end
            end

            always_ff @(posedge core_clk_in)
            begin
                if (rst_in)
                begin
                    active_r[c]   <= 1'b0;
                    count_r[c]    <= '0;
                    ram_addr_r[c] <= '0;
                    sfr_addr_r[c] <= '0;
                    done_r[c]     <= 1'b0;
                end
                else
                begin
                    done_r[c] <= 1'b0;
                    if (ch_load_in[c])
                    begin
                        count_r[c]    <= (ch_count_in[c*CW +: CW] >
                                          dmac_pkg::MAX_COUNT) ?
                                         dmac_pkg::MAX_COUNT :
                                         ch_count_in[c*CW +: CW];
                        ram_addr_r[c] <= ch_ram_addr_in[c*AW +: AW];
                        sfr_addr_r[c] <= ch_sfr_addr_in[c*AW +: AW];
                        active_r[c]   <= ch_enable_in[c] &&
                                         (ch_count_in[c*CW +: CW] != '0);
                    end
                    else if (state_r == dmac_pkg::ST_WRITE &&
                             cur_ch_r == 1'(c) && fifo_rd_valid)
                    begin
                        count_r[c]    <= count_r[c] - 1'b1;
                        ram_addr_r[c] <= ram_addr_r[c] +
                                         (ch_wide_in[c] ? AW'(2) :
                                                          AW'(1));
                        if (count_r[c] == CW'(1))
                        begin
                            active_r[c] <= 1'b0;
                            done_r[c]   <= 1'b1;
                        end
                    end
                end
            end
            assign ch_remain_out[c*CW +: CW] = count_r[c];
        end
    endgenerate

    // channel 0 wins when both are ready; each channel's hold
    // delay runs the same whether or not the engine is busy
    always_comb
    begin
        grant = '0;
        if (state_r == dmac_pkg::ST_IDLE && fifo_wr_ready)
        begin
            if (pend_r[0] && active_r[0] && !hold_eff[0])
            begin
                grant[0] = 1'b1;
            end
            else if (pend_r[1] && active_r[1] && !hold_eff[1])
            begin
                grant[1] = 1'b1;
            end
        end
    end
    assign start    = |grant;
    assign start_ch = grant[1];

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_r  <= dmac_pkg::ST_IDLE;
            cur_ch_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                dmac_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        state_r  <= dmac_pkg::ST_READ;
                        cur_ch_r <= start_ch;
                    end
                end
                dmac_pkg::ST_READ:
                begin
                    state_r <= dmac_pkg::ST_WRITE;
                end
                dmac_pkg::ST_WRITE:
                begin
                    if (fifo_rd_valid)
                    begin
                        state_r <= dmac_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= dmac_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign cur_wide   = ch_wide_in[cur_ch_r];
    assign cur_to_ram = ch_to_ram_in[cur_ch_r];
    // read side and write side are always one SFR, one RAM
    assign rd_addr = cur_to_ram ? sfr_addr_r[cur_ch_r] :
                                  ram_addr_r[cur_ch_r];
    assign wr_addr = cur_to_ram ? ram_addr_r[cur_ch_r] :
                                  sfr_addr_r[cur_ch_r];

    // read data is captured as the read cycle closes, so the write
    // cycle finds it waiting and the stall stays at two cycles
    dmac_fifo #(
        .WIDTH (dmac_pkg::DW),
        .DEPTH (dmac_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in  (core_clk_in),
        .rst_in       (rst_in),
        .wr_data_in   (cur_wide ? mem_rdata_in :
                       {8'h00, mem_rdata_in[7:0]}),
        .wr_valid_in  (state_r == dmac_pkg::ST_READ),
        .wr_ready_out (fifo_wr_ready),
        .rd_data_out  (fifo_rdata),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (fifo_rd_ready)
    );
    assign fifo_rd_ready = (state_r == dmac_pkg::ST_WRITE);

    always_comb
    begin
        mem_req_out   = 1'b0;
        mem_we_out    = 1'b0;
        mem_sfr_out   = 1'b0;
        mem_addr_out  = '0;
        mem_wdata_out = '0;
        case (state_r)
            dmac_pkg::ST_READ:
            begin
                mem_req_out  = 1'b1;
                mem_sfr_out  = cur_to_ram;
                mem_addr_out = rd_addr;
            end
            dmac_pkg::ST_WRITE:
            begin
                mem_req_out   = fifo_rd_valid;
                mem_we_out    = fifo_rd_valid;
                mem_sfr_out   = !cur_to_ram;
                mem_addr_out  = wr_addr;
                mem_wdata_out = fifo_rdata;
            end
            default:
            begin
                mem_req_out = 1'b0;
            end
        endcase
    end
    assign mem_wide_out    = cur_wide;
    assign cpu_stall_out   = (state_r != dmac_pkg::ST_IDLE);
    assign ch_busy_out     = active_r;
    assign ch_done_irq_out = done_r;
endmodule

/* File: dmac_checker.sv */
`timescale 1ns/1ps
module dmac_checker
(
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic [1:0]  channel_hold_bit_in,
    input wire logic        cpu_stall_out,
    input wire logic        mem_req_out,
    input wire logic        mem_we_out,
    input wire logic        mem_sfr_out,
    input wire logic        mem_wide_out,
    input wire logic [15:0] mem_wdata_out,
    input wire logic [1:0]  ch_done_irq_out,
    input wire logic [21:0] ch_remain_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    a_stall_two: assert property
        ($rose(cpu_stall_out) |=> cpu_stall_out ##1 !cpu_stall_out)
        else $error("stall not two cycles");
    a_stall_req: assert property (cpu_stall_out == mem_req_out)
        else $error("stall and request differ");
    a_read_write: assert property
        (mem_req_out && !mem_we_out |=> mem_req_out && mem_we_out)
        else $error("read not followed by write");
    a_write_idle: assert property
        (mem_req_out && mem_we_out |=> !mem_req_out)
        else $error("no idle after write");
    a_space_swap: assert property
        (mem_req_out && !mem_we_out |=> mem_sfr_out != $past(mem_sfr_out))
        else $error("read and write in same space");
    a_narrow_wdata: assert property
        (mem_req_out && mem_we_out && !mem_wide_out |->
         mem_wdata_out[15:8] == 8'h00)
        else $error("narrow write high byte set");
    a_done_pulse: assert property
        (|ch_done_irq_out |=>
         (ch_done_irq_out & $past(ch_done_irq_out)) == 2'h0)
        else $error("done longer than one cycle");
    a_done_zero: assert property
        ((!ch_done_irq_out[0] || ch_remain_out[10:0] == 11'h000) &&
         (!ch_done_irq_out[1] || ch_remain_out[21:11] == 11'h000))
        else $error("done with count left");
    a_done_after: assert property
        (|ch_done_irq_out |-> $past(mem_we_out))
        else $error("done without write");
    a_hold_both: assert property
        ((channel_hold_bit_in == 2'h3) [*3] |=> !(mem_req_out && !mem_we_out))
        else $error("transfer while held");
endmodule
bind dmac_top dmac_checker i_chk
(
    .core_clk_in         (core_clk_in),
    .rst_in              (rst_in),
    .channel_hold_bit_in (channel_hold_bit_in),
    .cpu_stall_out       (cpu_stall_out),
    .mem_req_out         (mem_req_out),
    .mem_we_out          (mem_we_out),
    .mem_sfr_out         (mem_sfr_out),
    .mem_wide_out        (mem_wide_out),
    .mem_wdata_out       (mem_wdata_out),
    .ch_done_irq_out     (ch_done_irq_out),
    .ch_remain_out       (ch_remain_out)
);

/* File: dmac_mem_model.sv */
`timescale 1ns/1ps
module dmac_mem_model
(
    input  wire logic        core_clk_in,
    input  wire logic        mem_req_in,
    input  wire logic        mem_we_in,
    input  wire logic [15:0] mem_addr_in,
    output logic      [15:0] mem_rdata_out
);
    logic [15:0] addr_r;
    logic        rd_r;
    // read data stands through the cycle after the read only
    always_ff @(posedge core_clk_in)
    begin
        rd_r   <= mem_req_in & ~mem_we_in;
        addr_r <= mem_addr_in;
    end
    always_comb
    begin
        if (mem_req_in && !mem_we_in)
            mem_rdata_out = {~mem_addr_in[7:0], mem_addr_in[7:0]};
        else if (rd_r)
            mem_rdata_out = {~addr_r[7:0], addr_r[7:0]};
        else
            mem_rdata_out = {addr_r[7:0], ~addr_r[7:0]};
    end
endmodule

/* File: dmac_top_tb.sv */
`timescale 1ns/1ps
module dmac_top_tb;
    logic        clk;
    logic        rst;
    logic [11:0] irq;
    logic [1:0]  en;
    logic [1:0]  wide;
    logic [1:0]  to_ram;
    logic [1:0]  hold;
    logic [1:0]  load;
    logic [7:0]  sel;
    logic [31:0] sfr;
    logic [31:0] ram;
    logic [21:0] cnt;
    logic        stall;
    logic        req;
    logic        we;
    logic        is_sfr;
    logic        wd_w;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [1:0]  busy;
    logic [1:0]  done;
    logic [21:0] remain;
    logic [15:0] ra;
    logic [15:0] wa;
    logic [15:0] wd;
    logic        rs;
    int          miscompares;
    int          num_checks;

    dmac_top i_dut(.core_clk_in(clk), .rst_in(rst), .irq_src_in(irq),
        .ch_enable_in(en), .ch_wide_in(wide), .ch_to_ram_in(to_ram),
        .channel_hold_bit_in(hold), .ch_load_in(load), .ch_src_sel_in(sel),
        .ch_sfr_addr_in(sfr), .ch_ram_addr_in(ram), .ch_count_in(cnt),
        .cpu_stall_out(stall), .mem_req_out(req), .mem_we_out(we),
        .mem_sfr_out(is_sfr), .mem_wide_out(wd_w), .mem_addr_out(addr),
        .mem_wdata_out(wdata), .mem_rdata_in(rdata), .ch_busy_out(busy),
        .ch_done_irq_out(done), .ch_remain_out(remain));
    dmac_mem_model i_mem(.core_clk_in(clk), .mem_req_in(req),
        .mem_we_in(we), .mem_addr_in(addr), .mem_rdata_out(rdata));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task cfg(input int c, input logic [3:0] s, input logic w, input logic t,
             input logic [15:0] sa, input logic [15:0] a,
             input logic [10:0] n);
        en[c] = 1'b1;
        wide[c] = w;
        to_ram[c] = t;
        sel[c*4+:4] = s;
        sfr[c*16+:16] = sa;
        ram[c*16+:16] = a;
        cnt[c*11+:11] = n;
        load[c] = 1'b1;
        @(negedge clk);
        load[c] = 1'b0;
    endtask
    task fire(input logic [11:0] m);
        irq = m;
        @(negedge clk);
        irq = 12'h000;
    endtask
    task xfer;
        int k;
        k = 0;
        while (!(req === 1'b1 && we === 1'b0) && k < 20)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 20)
        begin
            miscompares++;
            $display("FAIL %0t: no transfer", $time);
            stop_test();
        end
        ra = addr;
        rs = is_sfr;
        @(negedge clk);
        wa = addr;
        wd = wdata;
    endtask
    task quiet(input int n);
        repeat (n)
        begin
            @(negedge clk);
            check({15'h0000, req}, 16'h0000);
        end
    endtask
    task t_basic;
        cfg(0, dmac_pkg::SRC_ADC, 1'b0, 1'b1, 16'h0F10, 16'hE000, 11'h002);
        check({14'h0000, busy}, 16'h0001);
        fire(12'h001);
        xfer();
        check({15'h0000, stall}, 16'h0001);
        check({15'h0000, wd_w}, 16'h0000);
        check(ra, 16'h0F10);
        check({15'h0000, rs}, 16'h0001);
        check(wa, 16'hE000);
        check(wd, 16'h0010);
        fire(12'h001);
        xfer();
        check(wa, 16'hE001);
        @(negedge clk);
        check({14'h0000, done}, 16'h0001);
        check({5'h00, remain[10:0]}, 16'h0000);
        check({14'h0000, busy}, 16'h0000);
        check({15'h0000, stall}, 16'h0000);
        fire(12'h001);
        quiet(8);
        $display("test basic done");
    endtask
    task t_wide;
        cfg(1, dmac_pkg::SRC_TMR4, 1'b1, 1'b0, 16'h0F20, 16'hE100, 11'h002);
        cfg(0, dmac_pkg::SRC_TMR0, 1'b1, 1'b1, 16'h0F30, 16'hE200, 11'h001);
        fire(12'h500);
        xfer();
        check(ra, 16'h0F30);
        check(wd, 16'hCF30);
        check({15'h0000, wd_w}, 16'h0001);
        xfer();
        check(ra, 16'hE100);
        check(wa, 16'h0F20);
        check(wd, 16'hFF00);
        fire(12'h400);
        xfer();
        check(ra, 16'hE102);
        check(wa, 16'h0F20);
        $display("test wide done");
    endtask
    task t_sources;
        for (int s = 0; s < 12; s++)
        begin
            cfg(0, 4'(s), 1'b0, 1'b1, 16'h0F00, 16'hE300, 11'h001);
            fire(12'h001 << ((s + 1) % 12));
            quiet(4);
            fire(12'h001 << s);
            xfer();
            check(ra, 16'h0F00);
        end
        cfg(0, 4'hC, 1'b0, 1'b1, 16'h0F00, 16'hE300, 11'h001);
        fire(12'hFFF);
        quiet(4);
        $display("test sources done");
    endtask
    task t_hold;
        cfg(0, dmac_pkg::SRC_ADC, 1'b0, 1'b1, 16'h0F40, 16'hE400, 11'h003);
        hold = 2'h3;
        repeat (3) @(negedge clk);
        fire(12'h001);
        fire(12'h001);
        fire(12'h001);
        quiet(6);
        hold = 2'h0;
        xfer();
        check(wa, 16'hE400);
        quiet(8);
        irq = 12'h001;
        hold = 2'h1;
        @(negedge clk);
        irq = 12'h000;
        xfer();
        check(wa, 16'hE401);
        hold = 2'h0;
        $display("test hold done");
    endtask
    task t_reset;
        cfg(0, dmac_pkg::SRC_ADC, 1'b0, 1'b1, 16'h0F50, 16'hE500, 11'h002);
        fire(12'h001);
        rst = 1'b1;
        @(negedge clk);
        check({15'h0000, req}, 16'h0000);
        check({15'h0000, stall}, 16'h0000);
        check({14'h0000, busy}, 16'h0000);
        check({5'h00, remain[10:0]}, 16'h0000);
        rst = 1'b0;
        quiet(4);
        $display("test reset done");
    endtask
    initial
    begin
        miscompares = 0;
        num_checks = 0;
        rst = 1'b1;
        {irq, en, wide, to_ram, hold, load} = '0;
        {sel, sfr, ram, cnt} = '0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_basic();
        t_wide();
        t_sources();
        t_hold();
        t_reset();
        stop_test();
    end
endmodule
